// ---- rtl/sblhr_params.svh ----
/*
 * Offsets, field positions, reset values and timing counts of the serial-bus
 * link host register bank.
 * Assumes it is included by its bare name from the design.
 */
`ifndef SBLHR_PARAMS_SVH
`define SBLHR_PARAMS_SVH

// ****************************************************************************
// Configuration space offsets
// ****************************************************************************
`define SBLHR_CFG_MISC        8'h44
`define SBLHR_CFG_PHY         8'h46
`define SBLHR_CFG_HIDE        8'hf4
`define SBLHR_CFG_MAKER       8'hf8
`define SBLHR_CFG_BAR         8'h10

// ****************************************************************************
// Memory window offsets
// ****************************************************************************
`define SBLHR_WIN_MASK        32'hfffff800
`define SBLHR_MEM_VERSION     11'h000
`define SBLHR_MEM_RETRY       11'h008
`define SBLHR_MEM_SWAP_DATA   11'h00c
`define SBLHR_MEM_SWAP_CMP    11'h010
`define SBLHR_MEM_SWAP_CTL    11'h014
`define SBLHR_MEM_ROM_HDR     11'h018
`define SBLHR_MEM_BUS_ID      11'h01c
`define SBLHR_MEM_BUS_OPT     11'h020
`define SBLHR_MEM_UID_HI      11'h024
`define SBLHR_MEM_UID_LO      11'h028
`define SBLHR_MEM_LINK_SET    11'h050
`define SBLHR_MEM_LINK_CLR    11'h054

// ****************************************************************************
// Serial-bus addresses of the management resources
// ****************************************************************************
`define SBLHR_BM_ADDR         48'hfffff000021c
`define SBLHR_BW_ADDR         48'hfffff0000220
`define SBLHR_CHH_ADDR        48'hfffff0000224
`define SBLHR_CHL_ADDR        48'hfffff0000228

// ****************************************************************************
// Reset values and field positions
// ****************************************************************************
`define SBLHR_BUS_ID_VAL      32'h31333934
`define SBLHR_BM_RST          32'h0000003f
`define SBLHR_BW_RST          32'h00001333
`define SBLHR_CH_RST          32'hffffffff
`define SBLHR_BM_MASK         32'h0000003f
`define SBLHR_BW_MASK         32'h00001fff
`define SBLHR_OPT_RST         32'hf0000002
`define SBLHR_OPT_MASK        32'hf0fff0c7
`define SBLHR_HDR_MASK        32'hff00ffff
`define SBLHR_LINK_MASK       32'h000e0000
`define SBLHR_VERSION_VAL     32'h00000100
`define SBLHR_MAKER_VAL       32'h00001234
`define SBLHR_DONE_BIT        31
`define SBLHR_SECONDS_MOD     3'h7
`define SBLHR_CYCLES_MOD      13'd8000

// ****************************************************************************
// Timing
// ****************************************************************************
`define SBLHR_CYCLE_NS        125000
`define SBLHR_CLK_NS          10
`define SBLHR_CYCLE_CLKS      (`SBLHR_CYCLE_NS / `SBLHR_CLK_NS)

`endif

// ---- rtl/sblhr_pkg.sv ----
/*
 * Types of the serial-bus link host register bank.
 * Assumes the parameter header is on the include path.
 */
`default_nettype none
package sblhr_pkg;

  // Host access: configuration or memory cycle.
  typedef struct packed {
    logic        cfg_req;
    logic        mem_req;
    logic        we;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } sblhr_host_req_type;

  // Serial-bus request toward a management resource.
  typedef struct packed {
    logic        req;
    logic        lock;
    logic [3:0]  len;
    logic [47:0] addr;
    logic [31:0] arg;
    logic [31:0] data;
  } sblhr_link_req_type;

  // Transmit retry setting handed to the transmit paths.
  typedef struct packed {
    logic [3:0] phys;
    logic [3:0] resp;
    logic [3:0] req;
  } sblhr_retry_type;

  typedef enum logic [2:0] {
    SBLHR_IDLE = 3'b001,
    SBLHR_SWAP = 3'b010,
    SBLHR_DONE = 3'b100
  } sblhr_state_type;

  typedef struct packed {
    sblhr_state_type state;
    logic        uid_lock;
    logic        hide;
    logic [1:0]  phy_ctl;
    logic [31:0] uid_hi;
    logic [31:0] uid_lo;
    logic [31:0] bar;
    logic [11:0] retry;
    logic [31:0] swap_data;
    logic [31:0] swap_cmp;
    logic        done;
    logic [1:0]  sel;
    logic [31:0] rom_hdr;
    logic [31:0] bus_opt;
    logic [31:0] link_ctl;
    logic [3:0][31:0] res;
    logic [2:0]  seconds;
    logic [12:0] cycles;
    logic [13:0] tick;
    logic [31:0] rdata;
    logic        abort;
    logic        ack_err;
    logic [31:0] lk_rdata;
  } sblhr_state_all_type;

endpackage : sblhr_pkg
`default_nettype wire

// ---- rtl/sblhr_regs.sv ----
/*
 * Host-visible register bank of a serial-bus link controller on a PCI-style
 * host bus: configuration bits, the 2 KB memory window and the
 * compare-and-swap management resources.
 * Assumes the host decoder presents one access per cycle with a one-cycle
 * answer, and that the link layer presents serial-bus reads and locks.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sblhr_params.svh"

// Overview of operation
// - Lock bit makes unique-identifier words read-only; only PCI reset clears it.
// - Concatenation-disable zero allows mixed speeds except down to S100; one forbids.
// - Hide bit set makes later configuration cycles master-abort; PCI reset clears.
// - Decode a 2048-byte memory window at the programmed base address.
// - Either address of a set/clear pair reads contents; set address sets ones.
// - Clear address of a pair clears bits written as one, others kept.
// - Retry register shows read-only seconds mod 8 and cycles mod 8000.
// - Physical responses retry up to count in bits 11-8.
// - Software-queued responses retry up to count in bits 7-4.
// - Transmit requests retry up to count in bits 3-0.
// - Serial-bus compare-and-swap on management resources runs wholly in hardware.
// - Control write starts swap; done sets, data gets former resource value.
// - Only 32-bit reads and 32-bit locks reach management resources.
// - Done bit resets to one, sets on completion, clears on control write.
// - Select 00 manager, 01 bandwidth, 10 upper channels, 11 lower channels.
// - ROM header bits 31-24 hold bus info length, default zero.
// - ROM CRC loads from identifier ROM if present; software sets before link.
// - Bus identifier register always reads 31333934h.
// - Bus options bits 31-28 are capability bits resetting to capable.
// - Software programs clock accuracy and max write length before link enable.
// - ROM-changed bits 7-6 default zero; max speed bits 2-0 default 010.
module sblhr_regs (
  // Clock and resets
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       soft_rst,
  input  wire logic                       bus_rst,
  // Host access
  input  wire sblhr_pkg::sblhr_host_req_type host_req,
  output logic [31:0]                     host_rdata,
  output logic                            host_abort,
  // Identifier ROM
  input  wire logic                       rom_present,
  input  wire logic [15:0]                rom_crc,
  // Serial-bus resource access
  input  wire sblhr_pkg::sblhr_link_req_type link_req,
  output logic [31:0]                     link_rdata,
  output logic                            link_type_err,
  // Controls toward link and PHY
  output sblhr_pkg::sblhr_retry_type      retry_limits,
  output logic [2:0]                      retry_seconds,
  output logic [12:0]                     retry_cycles,
  output logic                            phy_isolated,
  output logic                            mixed_speed_ok,
  output logic [31:0]                     link_control
);

  sblhr_pkg::sblhr_state_all_type s_r;
  sblhr_pkg::sblhr_state_all_type s_nxt;

  // Decode of the current host access and of the serial-bus request.
  logic [10:0] off;
  logic        in_win;
  logic        hw;
  logic        lk_hit;
  logic [1:0]  lk_sel;
  logic [31:0] old_val;
  logic [31:0] rmask;

  // Resource mask by select code.
  function automatic logic [31:0] res_mask(input logic [1:0] sel);
    unique case (sel)
      2'b00:   res_mask = `SBLHR_BM_MASK;
      2'b01:   res_mask = `SBLHR_BW_MASK;
      default: res_mask = `SBLHR_CH_RST;
    endcase
  endfunction

  assign off    = host_req.addr[10:0];
  assign in_win = host_req.mem_req &&
                  ((host_req.addr & `SBLHR_WIN_MASK) == (s_r.bar & `SBLHR_WIN_MASK));
  assign hw     = in_win && host_req.we && (host_req.be == 4'hf);

  // ****************************************************************************
  // Serial-bus address decode
  // ****************************************************************************
  always_comb begin
    lk_hit = 1'b1;
    lk_sel = 2'b00;
    unique case (link_req.addr)
      `SBLHR_BM_ADDR:  lk_sel = 2'b00;
      `SBLHR_BW_ADDR:  lk_sel = 2'b01;
      `SBLHR_CHH_ADDR: lk_sel = 2'b10;
      `SBLHR_CHL_ADDR: lk_sel = 2'b11;
      default:         lk_hit = 1'b0;
    endcase
  end

  // The resource that a host swap works on, chosen by the latched select.
  assign old_val = s_r.res[s_r.sel];
  assign rmask   = res_mask(s_r.sel);

  always_comb begin
    // Host read data and pulses stand for one cycle, so they fall back to zero.
    s_nxt          = s_r;
    s_nxt.abort    = 1'b0;
    s_nxt.ack_err  = 1'b0;
    s_nxt.rdata    = 32'h0;

    // Cycle-time count for the retry window; wraps at 8 seconds and 8000 cycles.
    if (s_r.tick == 14'(`SBLHR_CYCLE_CLKS - 1)) begin
      s_nxt.tick = 14'h0;
      if (s_r.cycles == `SBLHR_CYCLES_MOD - 13'h1) begin
        s_nxt.cycles  = 13'h0;
        s_nxt.seconds = s_r.seconds + 3'h1;
      end else begin
        s_nxt.cycles = s_r.cycles + 13'h1;
      end
    end else begin
      s_nxt.tick = s_r.tick + 14'h1;
    end

    // ****************************************************************************
    // Configuration space
    // ****************************************************************************
    // A hidden function also drops its writes, so software cannot unhide it.
    if (host_req.cfg_req) begin
      if (s_r.hide) begin
        s_nxt.abort = 1'b1;
      end else if (host_req.we) begin
        unique case (host_req.addr[7:0])
          `SBLHR_CFG_MISC: s_nxt.uid_lock = s_r.uid_lock | host_req.wdata[0];
          `SBLHR_CFG_PHY:  s_nxt.phy_ctl  = host_req.wdata[1:0];
          `SBLHR_CFG_HIDE: s_nxt.hide     = s_r.hide | host_req.wdata[0];
          `SBLHR_CFG_BAR:  s_nxt.bar      = {host_req.wdata[31:7], 7'h0};
          default: ;
        endcase
      end else begin
        unique case (host_req.addr[7:0])
          `SBLHR_CFG_MISC:  s_nxt.rdata = {31'h0, s_r.uid_lock};
          `SBLHR_CFG_PHY:   s_nxt.rdata = {30'h0, s_r.phy_ctl};
          `SBLHR_CFG_HIDE:  s_nxt.rdata = {31'h0, s_r.hide};
          `SBLHR_CFG_MAKER: s_nxt.rdata = `SBLHR_MAKER_VAL;
          `SBLHR_CFG_BAR:   s_nxt.rdata = s_r.bar;
          default:          s_nxt.rdata = 32'h0;
        endcase
      end
    end

    // ****************************************************************************
    // Memory window
    // ****************************************************************************
    if (in_win && !host_req.we) begin
      unique case (off)
        `SBLHR_MEM_VERSION:   s_nxt.rdata = `SBLHR_VERSION_VAL;
        `SBLHR_MEM_RETRY:     s_nxt.rdata = {s_r.seconds, s_r.cycles, 4'h0, s_r.retry};
        `SBLHR_MEM_SWAP_DATA: s_nxt.rdata = s_r.swap_data;
        `SBLHR_MEM_SWAP_CMP:  s_nxt.rdata = s_r.swap_cmp;
        `SBLHR_MEM_SWAP_CTL:  s_nxt.rdata = {s_r.done, 29'h0, s_r.sel};
        `SBLHR_MEM_ROM_HDR:   s_nxt.rdata = s_r.rom_hdr;
        `SBLHR_MEM_BUS_ID:    s_nxt.rdata = `SBLHR_BUS_ID_VAL;
        `SBLHR_MEM_BUS_OPT:   s_nxt.rdata = s_r.bus_opt;
        `SBLHR_MEM_UID_HI:    s_nxt.rdata = s_r.uid_hi;
        `SBLHR_MEM_UID_LO:    s_nxt.rdata = s_r.uid_lo;
        `SBLHR_MEM_LINK_SET,
        `SBLHR_MEM_LINK_CLR:  s_nxt.rdata = s_r.link_ctl;
        default:              s_nxt.rdata = 32'h0;
      endcase
    end
    // Partial writes are dropped whole, so no field is left half old, half new.
    if (hw) begin
      unique case (off)
        `SBLHR_MEM_RETRY:     s_nxt.retry = host_req.wdata[11:0];
        `SBLHR_MEM_SWAP_DATA: s_nxt.swap_data = host_req.wdata;
        `SBLHR_MEM_SWAP_CMP:  s_nxt.swap_cmp  = host_req.wdata;
        `SBLHR_MEM_SWAP_CTL: begin
          s_nxt.sel   = host_req.wdata[1:0];
          s_nxt.done  = 1'b0;
          s_nxt.state = sblhr_pkg::SBLHR_SWAP;
        end
        `SBLHR_MEM_ROM_HDR:   s_nxt.rom_hdr = host_req.wdata & `SBLHR_HDR_MASK;
        `SBLHR_MEM_BUS_OPT:   s_nxt.bus_opt = host_req.wdata & `SBLHR_OPT_MASK;
        `SBLHR_MEM_UID_HI:    if (!s_r.uid_lock) s_nxt.uid_hi = host_req.wdata;
        `SBLHR_MEM_UID_LO:    if (!s_r.uid_lock) s_nxt.uid_lo = host_req.wdata;
        `SBLHR_MEM_LINK_SET:
          s_nxt.link_ctl = s_r.link_ctl | (host_req.wdata & `SBLHR_LINK_MASK);
        `SBLHR_MEM_LINK_CLR:
          s_nxt.link_ctl = s_r.link_ctl & ~(host_req.wdata & `SBLHR_LINK_MASK);
        default: ;
      endcase
    end

    // ****************************************************************************
    // Host compare-and-swap
    // ****************************************************************************
    unique case (s_r.state)
      sblhr_pkg::SBLHR_IDLE: ;
      sblhr_pkg::SBLHR_SWAP: begin
        // Reserved bits are masked on both sides, so they never decide a compare.
        if (old_val == (s_r.swap_cmp & rmask))
          s_nxt.res[s_r.sel] = s_r.swap_data & rmask;
        s_nxt.swap_data = old_val;
        s_nxt.state     = sblhr_pkg::SBLHR_DONE;
      end
      sblhr_pkg::SBLHR_DONE: begin
        s_nxt.done  = 1'b1;
        s_nxt.state = sblhr_pkg::SBLHR_IDLE;
      end
      default: s_nxt.state = sblhr_pkg::SBLHR_IDLE;
    endcase

    // ****************************************************************************
    // Serial-bus access, served with no host help; a host swap in flight wins
    // ****************************************************************************
    if (link_req.req && lk_hit) begin
      if (link_req.len != 4'h4) begin
        s_nxt.ack_err = 1'b1;
      end else begin
        s_nxt.lk_rdata = s_r.res[lk_sel];
        if (link_req.lock && s_r.state != sblhr_pkg::SBLHR_SWAP &&
            s_r.res[lk_sel] == (link_req.arg & res_mask(lk_sel)))
          s_nxt.res[lk_sel] = link_req.data & res_mask(lk_sel);
      end
    end

    if (rom_present && s_r.rom_hdr[15:0] == 16'h0 && s_r.state == sblhr_pkg::SBLHR_IDLE)
      s_nxt.rom_hdr[15:0] = rom_crc;

    // Bus reset restores the management resources only.
    if (bus_rst) begin
      s_nxt.res[0] = `SBLHR_BM_RST;
      s_nxt.res[1] = `SBLHR_BW_RST;
      s_nxt.res[2] = `SBLHR_CH_RST;
      s_nxt.res[3] = `SBLHR_CH_RST;
    end
    // Soft reset leaves identifier words and configuration bits alone.
    if (soft_rst) begin
      s_nxt.link_ctl = 32'h0;
      s_nxt.retry    = 12'h0;
      s_nxt.done     = 1'b1;
      s_nxt.state    = sblhr_pkg::SBLHR_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Clear the whole state first, then restore the defaults that are not zero.
      s_r          <= '0;
      s_r.state    <= sblhr_pkg::SBLHR_IDLE;
      s_r.done     <= 1'b1;
      s_r.bus_opt  <= `SBLHR_OPT_RST;
      s_r.res[0]   <= `SBLHR_BM_RST;
      s_r.res[1]   <= `SBLHR_BW_RST;
      s_r.res[2]   <= `SBLHR_CH_RST;
      s_r.res[3]   <= `SBLHR_CH_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign host_rdata     = s_r.rdata;
  assign host_abort     = s_r.abort;
  assign link_rdata     = s_r.lk_rdata;
  assign link_type_err  = s_r.ack_err;
  assign retry_limits   = s_r.retry;
  assign retry_seconds  = s_r.seconds;
  assign retry_cycles   = s_r.cycles;
  assign phy_isolated   = s_r.phy_ctl[1];
  assign mixed_speed_ok = ~s_r.phy_ctl[0];
  assign link_control   = s_r.link_ctl;

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  // Configuration, identifier and memory window checks.
  a_hide_aborts: assert property (@(posedge clk) disable iff (sys_rst)
    host_req.cfg_req && s_r.hide |=> host_abort) else $error("hidden function not aborted");

  a_hide_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.hide |=> s_r.hide) else $error("hide bit cleared");

  a_lock_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.uid_lock |=> s_r.uid_lock) else $error("lock bit cleared");

  a_uid_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.uid_lock |=> $stable(s_r.uid_hi) && $stable(s_r.uid_lo)) else $error("uid changed");

  a_window_miss: assert property (@(posedge clk) disable iff (sys_rst)
    host_req.mem_req && !host_req.cfg_req && !in_win |=> host_rdata == 32'h0)
    else $error("read outside window answered");

  // Host swap and register checks.
  a_swap_done: assert property (@(posedge clk) disable iff (sys_rst || soft_rst)
    hw && off == `SBLHR_MEM_SWAP_CTL |=> !s_r.done ##1 !s_r.done ##1 s_r.done)
    else $error("swap done timing wrong");

  a_swap_old: assert property (@(posedge clk)
    disable iff (sys_rst || soft_rst || bus_rst)
    s_r.state == sblhr_pkg::SBLHR_SWAP |=> s_r.swap_data == $past(old_val))
    else $error("swap data not former value");

  a_set_clear: assert property (@(posedge clk) disable iff (sys_rst || soft_rst)
    hw && off == `SBLHR_MEM_LINK_CLR |=> (s_r.link_ctl & $past(host_req.wdata)) == 32'h0)
    else $error("clear failed");

  a_soft_clear: assert property (@(posedge clk) disable iff (sys_rst)
    soft_rst |=> s_r.done && s_r.link_ctl == 32'h0 && s_r.retry == 12'h0)
    else $error("soft reset left state");

  a_opt_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    (s_r.bus_opt & ~`SBLHR_OPT_MASK) == 32'h0) else $error("bus options reserved bit set");

  a_hdr_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.rom_hdr[23:16] == 8'h0) else $error("rom header reserved bits set");

  a_rom_crc: assert property (@(posedge clk) disable iff (sys_rst)
    rom_present && s_r.rom_hdr[15:0] == 16'h0 && s_r.state == sblhr_pkg::SBLHR_IDLE
    |=> s_r.rom_hdr[15:0] == $past(rom_crc)) else $error("rom crc not loaded");

  a_cycles_mod: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.cycles < `SBLHR_CYCLES_MOD) else $error("cycles out of range");

  // Serial-bus resource checks.
  a_bad_len: assert property (@(posedge clk) disable iff (sys_rst)
    link_req.req && lk_hit && link_req.len != 4'h4 |=> link_type_err)
    else $error("bad length accepted");

  a_link_old: assert property (@(posedge clk) disable iff (sys_rst)
    link_req.req && lk_hit && link_req.len == 4'h4 |=> link_rdata == $past(s_r.res[lk_sel]))
    else $error("link read not former value");

  a_bus_reset: assert property (@(posedge clk) disable iff (sys_rst)
    bus_rst |=> s_r.res[0] == `SBLHR_BM_RST && s_r.res[1] == `SBLHR_BW_RST &&
    s_r.res[2] == `SBLHR_CH_RST && s_r.res[3] == `SBLHR_CH_RST)
    else $error("bus reset left resources");

  c_host_swap: cover property (@(posedge clk) s_r.state == sblhr_pkg::SBLHR_DONE);
  c_link_lock: cover property (@(posedge clk) link_req.req && link_req.lock && lk_hit);
  c_hidden: cover property (@(posedge clk) host_abort);
  c_type_err: cover property (@(posedge clk) link_type_err);
  c_bus_reset: cover property (@(posedge clk) bus_rst);

endmodule : sblhr_regs

`default_nettype wire

// ---- verif/sblhr_regs_tb_top.sv ----
/*
 * Self-checking bench of the register bank: host and serial-bus traffic.
 * Assumes one-cycle answers on both sides and the window based at zero after reset.
 */
`timescale 1ns/1ns
`default_nettype none

module sblhr_regs_tb_top;
  logic                          clk, sys_rst, soft_rst, bus_rst, rom_present;
  logic [15:0]                   rom_crc;
  sblhr_pkg::sblhr_host_req_type host_req;
  sblhr_pkg::sblhr_link_req_type link_req;
  logic [31:0]                   host_rdata, link_rdata, link_control;
  logic                          host_abort, link_type_err, phy_isolated, mixed_speed_ok;
  sblhr_pkg::sblhr_retry_type    retry_limits;
  logic [2:0]                    retry_seconds;
  logic [12:0]                   retry_cycles;
  int                            mismatches, checks, cycles_run;
  logic [31:0]                   rnd, base, rd, exp_v, uid;
  logic [31:0]                   res_m [4];
  logic                          ab, er;

  sblhr_regs sblhr_regs_inst (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
    .bus_rst(bus_rst), .host_req(host_req), .host_rdata(host_rdata), .host_abort(host_abort),
    .rom_present(rom_present), .rom_crc(rom_crc), .link_req(link_req),
    .link_rdata(link_rdata), .link_type_err(link_type_err), .retry_limits(retry_limits),
    .retry_seconds(retry_seconds), .retry_cycles(retry_cycles), .phy_isolated(phy_isolated),
    .mixed_speed_ok(mixed_speed_ok), .link_control(link_control));

  sblhr_remote_node sblhr_remote_node_inst (.clk(clk), .link_req(link_req),
    .link_rdata(link_rdata), .link_type_err(link_type_err));

  always #5 clk = ~clk;

  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] res_reset(input int s);
    return (s == 0) ? 32'h0000003f : (s == 1) ? 32'h00001333 : 32'hffffffff;
  endfunction

  function automatic logic [31:0] res_mask(input int s);
    return (s == 0) ? 32'h0000003f : (s == 1) ? 32'h00001fff : 32'hffffffff;
  endfunction

  task automatic host(input logic cfg, input logic we, input logic [31:0] addr,
                      input logic [31:0] wdata);
    logic [31:0] a;
    a = cfg ? addr : base + addr;
    @(posedge clk);
    host_req <= '{cfg_req: cfg, mem_req: !cfg, we: we, addr: a, be: 4'hf, wdata: wdata};
    @(posedge clk);
    host_req <= '{cfg_req: 1'b0, mem_req: 1'b0, we: 1'b0, addr: ~a, be: 4'h0, wdata: ~wdata};
    #1;
    rd = host_rdata;
    ab = host_abort;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The whole run needs about 160 cycles.
  always @(posedge clk) begin
    cycles_run++;
    if (cycles_run == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************************************************
  // Main sequence
  // ****************************************************************************
  initial begin
    clk = 1'b0; sys_rst = 1'b1; soft_rst = 1'b0; bus_rst = 1'b0; rom_present = 1'b1;
    rnd = lfsr_next(32'he33c);
    rom_crc = rnd[15:0] | 16'h0001;
    host_req = '0; base = 32'h0; mismatches = 0; checks = 0; cycles_run = 0;
    for (int s = 0; s < 4; s++) res_m[s] = res_reset(s);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    host(0, 0, 32'h01c, 0); check(rd, 32'h31333934);
    host(0, 0, 32'h020, 0); check(rd, 32'hf0000002);
    host(0, 1, 32'h020, 32'hffffffff);
    host(0, 0, 32'h020, 0); check(rd, 32'hf0fff0c7);
    host(0, 0, 32'h018, 0); check(32'(rd[31:24]), 32'h0);
    check(32'(rd[15:0]), 32'(rom_crc));
    host(0, 0, 32'h014, 0); check(rd & 32'h80000000, 32'h80000000);
    rnd = lfsr_next(rnd);
    host(0, 1, 32'h008, rnd | 32'hffff0000);
    host(0, 0, 32'h008, 0); check(rd, 32'(rnd[11:0]));
    check(32'({retry_seconds, retry_cycles}), 32'h0);
    check(32'(retry_limits.phys), 32'(rnd[11:8]));
    check(32'(retry_limits.resp), 32'(rnd[7:4]));
    check(32'(retry_limits.req), 32'(rnd[3:0]));
    rnd = lfsr_next(rnd);
    host(0, 1, 32'h050, rnd | 32'h00020000);
    exp_v = (rnd | 32'h00020000) & 32'h000e0000;
    host(0, 0, 32'h054, 0); check(rd, exp_v);
    host(0, 1, 32'h054, 32'h00020000);
    exp_v = exp_v & 32'hfffdffff;
    host(0, 0, 32'h050, 0); check(rd, exp_v);
    check(link_control, exp_v);
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    host(0, 0, 32'h050, 0); check(rd, 32'h0);
    // Even selects compare equal and swap; odd selects miss and keep their value.
    for (int s = 0; s < 4; s++) begin
      rnd = lfsr_next(rnd);
      exp_v = rnd & res_mask(s);
      host(0, 1, 32'h00c, exp_v);
      host(0, 1, 32'h010, s[0] ? ~res_m[s] : res_m[s]);
      host(0, 1, 32'h014, 32'(s));
      repeat (4) @(posedge clk);
      host(0, 0, 32'h014, 0); check(rd, 32'h80000000 | 32'(s));
      host(0, 0, 32'h00c, 0); check(rd, res_m[s]);
      if (!s[0]) res_m[s] = exp_v;
    end
    for (int s = 0; s < 4; s++) begin
      rnd = lfsr_next(rnd);
      exp_v = rnd & res_mask(s);
      sblhr_remote_node_inst.access(0, 4'd4, 48'hfffff000021c + 48'(4 * s), 0, 0, rd, er);
      check(rd, res_m[s]);
      sblhr_remote_node_inst.access(1, 4'd4, 48'hfffff000021c + 48'(4 * s), res_m[s], exp_v, rd, er);
      check(rd, res_m[s]);
      res_m[s] = exp_v;
    end
    sblhr_remote_node_inst.access(1, 4'd8, 48'hfffff000021c, res_m[0], 0, rd, er);
    check(32'(er), 32'h1);
    sblhr_remote_node_inst.access(0, 4'd4, 48'hfffff000021c, 0, 0, rd, er);
    check(rd, res_m[0]);
    @(posedge clk) bus_rst <= 1'b1;
    @(posedge clk) bus_rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      sblhr_remote_node_inst.access(0, 4'd4, 48'hfffff000021c + 48'(4 * s), 0, 0, rd, er);
      check(rd, res_reset(s));
    end
    sblhr_remote_node_inst.access(1, 4'd4, 48'hfffff000021c, 32'h0, 32'h5, rd, er);
    check(rd, 32'h3f);
    sblhr_remote_node_inst.access(0, 4'd4, 48'hfffff000021c, 0, 0, rd, er);
    check(rd, 32'h3f);
    rnd = lfsr_next(rnd);
    uid = rnd;
    host(0, 1, 32'h024, uid);
    host(1, 1, 32'h44, 32'h1);
    host(0, 1, 32'h024, ~uid);
    host(0, 0, 32'h024, 0); check(rd, uid);
    host(1, 1, 32'h44, 32'h0);
    host(0, 1, 32'h024, ~uid);
    host(0, 0, 32'h024, 0); check(rd, uid);
    for (int v = 0; v < 4; v++) begin
      host(1, 1, 32'h46, 32'(v));
      check(32'(phy_isolated), 32'(v[1]));
      check(32'(mixed_speed_ok), 32'(!v[0]));
    end
    host(1, 1, 32'h10, 32'h00010000);
    host(0, 0, 32'h01c, 0); check(rd, 32'h0);
    base = 32'h00010000;
    host(0, 0, 32'h01c, 0); check(rd, 32'h31333934);
    host(0, 0, 32'h800, 0); check(rd, 32'h0);
    host(1, 0, 32'h44, 0); check(rd, 32'h1);
    check(32'(ab), 32'h0);
    host(1, 1, 32'hf4, 32'h1);
    host(1, 0, 32'h44, 0); check(32'(ab), 32'h1);
    host(1, 1, 32'hf4, 32'h0); check(32'(ab), 32'h1);
    host(1, 0, 32'hf8, 0); check(32'(ab), 32'h1);
    stop_test();
  end

endmodule // sblhr_regs_tb_top
`default_nettype wire

// ---- verif/sblhr_remote_node.sv ----
/*
 * Model of a remote serial-bus node that reads and locks the management
 * resources of the register bank.
 * Assumes one clock shared with the bank and an answer one cycle after a request.
 */
`timescale 1ns/1ns
`default_nettype none

module sblhr_remote_node (
  // Clock
  input  wire logic                          clk,
  // Request toward the bank
  output var  sblhr_pkg::sblhr_link_req_type link_req,
  // Answer from the bank
  input  wire logic [31:0]                   link_rdata,
  input  wire logic                          link_type_err
);

  initial link_req = '0;

  // ****************************************************************************
  // One transaction
  // ****************************************************************************
  // Released fields other than req and lock show the inverse so that a stale value is never mistaken for live data.
  task automatic access(input logic lock, input logic [3:0] len, input logic [47:0] addr,
                        input logic [31:0] arg, input logic [31:0] data,
                        output logic [31:0] old, output logic err);
    @(posedge clk);
    link_req <= '{req: 1'b1, lock: lock, len: len, addr: addr, arg: arg, data: data};
    @(posedge clk);
    link_req <= '{req: 1'b0, lock: 1'b0, len: ~len, addr: ~addr, arg: ~arg, data: ~data};
    #1;
    old = link_rdata;
    err = link_type_err;
  endtask

endmodule // sblhr_remote_node
`default_nettype wire
